// ### cao_regs.svh
`ifndef CAO_REGS_SVH
`define CAO_REGS_SVH
// ==========================================================
// power-on values of the core registers
`define CAO_A_POR      8'h00
`define CAO_X_POR      8'h00
`define CAO_SP_POR     8'h00
`define CAO_F_POR      8'h02
`define CAO_PC_POR     16'h0000
// ==========================================================
// flag register bit positions
`define CAO_F_BANK     3'h4
`define CAO_F_SUPER    3'h3
`define CAO_F_CARRY    3'h2
`define CAO_F_ZERO     3'h1
// ==========================================================
// opcode field layout
`define CAO_OPC_MODE_HI  3'h7
`define CAO_OPC_MODE_LO  3'h4
`define CAO_OPC_SPACE    3'h3
`define CAO_OPC_RSEL_HI  3'h3
`define CAO_OPC_RSEL_LO  3'h2
`define CAO_OPC_ALU_HI   3'h1
`define CAO_OPC_ALU_LO   3'h0
// ==========================================================
// operation codes, lengths and increments
`define CAO_ALU_MOVE   2'h0
`define CAO_LEN_SHORT  2'h2
`define CAO_LEN_LONG   2'h3
`define CAO_PC_STEP    16'h0001
`define CAO_PTR_STEP   8'h01
`define CAO_MODE_LAST  4'h9
`endif

// ### cao_pkg.sv
package cao_pkg;
   // ==========================================================
   // addressing modes, taken from the opcode high nibble
   typedef enum logic [3:0] {
      M_SIMM  = 4'b0000, // source immediate
      M_SDIR  = 4'b0001, // source direct
      M_SIDX  = 4'b0010, // source indexed
      M_DDIR  = 4'b0011, // destination direct
      M_DIDX  = 4'b0100, // destination indexed
      M_DDIMM = 4'b0101, // destination direct immediate
      M_DXIMM = 4'b0110, // destination indexed immediate
      M_DDD   = 4'b0111, // destination direct direct
      M_SIPI  = 4'b1000, // source indirect post increment
      M_DIPI  = 4'b1001  // destination indirect post increment
   } cao_mode_e;
   // ==========================================================
   // core register selection
   typedef enum logic [1:0] {
      R_A  = 2'b00,
      R_X  = 2'b01,
      R_F  = 2'b10,
      R_SP = 2'b11
   } cao_reg_e;
   // ==========================================================
   // sequencer states
   typedef enum logic [3:0] {
      ST_OPC  = 4'b0000, // fetch opcode
      ST_OP1  = 4'b0001, // fetch first operand
      ST_OP2  = 4'b0010, // fetch second operand
      ST_EXEC = 4'b0011, // dispatch on mode
      ST_RSRC = 4'b0100, // wait source read
      ST_RDST = 4'b0101, // wait destination read
      ST_RPTR = 4'b0110, // wait pointer read
      ST_RIND = 4'b0111, // wait indirect access
      ST_ALU  = 4'b1000, // combine and write back
      ST_WAITW = 4'b1001 // wait final write
   } cao_st_e;
   // ==========================================================
   // decoded instruction
   typedef struct packed {
      cao_mode_e  mode;
      cao_reg_e   rsel;
      logic       space;   // 1 = register space
      logic [1:0] alu_op;
      logic       is_move;
      logic [1:0] len;
      logic       indexed;
      logic       dest_mem;
      logic       legal;
   } cao_dec_s;
   // ==========================================================
   // data ram / register space request
   typedef struct packed {
      logic       req;
      logic       we;
      logic       regsp;
      logic       bank;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cao_dm_s;
   // ==========================================================
   // complete sequencer state
   typedef struct packed {
      cao_st_e     st;
      logic [15:0] pc;
      logic [7:0]  opc;
      logic [7:0]  op1;
      logic [7:0]  op2;
      logic [7:0]  a;
      logic [7:0]  x;
      logic [7:0]  sp;
      logic [7:0]  f;
      logic [7:0]  ptr;
      logic [7:0]  ea;
      logic [7:0]  srcv;
      logic [7:0]  alu_a;
      logic [7:0]  alu_b;
      logic        pm_req;
      cao_dm_s     dm;
      logic        done;
      logic        bad;
   } cao_state_s;
endpackage

// ### cao_mode_dec.sv
`timescale 1ns/1ps
`default_nettype none
`include "cao_regs.svh"
module cao_mode_dec (
   input  wire logic [7:0]       opc,
   output cao_pkg::cao_dec_s     dec
);
   // ==========================================================
   // opcode to mode, register, length and legality
   always_comb begin
      dec         = '0;
      dec.mode    = cao_pkg::cao_mode_e'(opc[`CAO_OPC_MODE_HI:`CAO_OPC_MODE_LO]);
      dec.alu_op  = opc[`CAO_OPC_ALU_HI:`CAO_OPC_ALU_LO];
      dec.is_move = (dec.alu_op == `CAO_ALU_MOVE);
      dec.space   = opc[`CAO_OPC_SPACE];
      dec.rsel    = cao_pkg::cao_reg_e'({1'b0, opc[`CAO_OPC_RSEL_LO]});
      dec.len     = `CAO_LEN_SHORT; // see (RULE2)
      dec.legal   = (opc[`CAO_OPC_MODE_HI:`CAO_OPC_MODE_LO] <= `CAO_MODE_LAST);
      case (dec.mode)
         cao_pkg::M_SIMM: begin
            // any of the four core registers
            dec.rsel  = cao_pkg::cao_reg_e'(opc[`CAO_OPC_RSEL_HI:`CAO_OPC_RSEL_LO]); // see (RULE1)
            dec.space = 1'b0;
         end
         cao_pkg::M_SIDX: begin
            dec.indexed = 1'b1;
         end
         cao_pkg::M_DDIR: begin
            dec.dest_mem = 1'b1;
         end
         cao_pkg::M_DIDX: begin
            dec.indexed  = 1'b1;
            dec.dest_mem = 1'b1;
            dec.rsel     = cao_pkg::R_A; // see (RULE9)
         end
         cao_pkg::M_DDIMM: begin
            dec.dest_mem = 1'b1;
            dec.len      = `CAO_LEN_LONG; // see (RULE3)
         end
         cao_pkg::M_DXIMM: begin
            dec.indexed  = 1'b1;
            dec.dest_mem = 1'b1;
            dec.len      = `CAO_LEN_LONG; // see (RULE3)
         end
         cao_pkg::M_DDD: begin
            // ram only, move only
            dec.dest_mem = 1'b1;
            dec.space    = 1'b0;
            dec.len      = `CAO_LEN_LONG; // see (RULE3)
            dec.legal    = dec.is_move; // see (RULE12)
         end
         cao_pkg::M_SIPI, cao_pkg::M_DIPI: begin
            // pointer modes only for the indirect move
            dec.space    = 1'b0;
            dec.rsel     = cao_pkg::R_A;
            dec.dest_mem = (dec.mode == cao_pkg::M_DIPI);
            dec.legal    = dec.is_move; // see (RULE16)
         end
         default: begin
            // source direct uses the defaults
         end
      endcase
   end
endmodule
`default_nettype wire

// ### cao_ea_add.sv
`timescale 1ns/1ps
`default_nettype none
module cao_ea_add (
   input  wire logic [7:0] base,
   input  wire logic [7:0] index,
   input  wire logic       indexed,
   output logic      [7:0] ea
);
   // ==========================================================
   // 8-bit address sum, carry dropped, no flag effect
   always_comb begin
      ea = indexed ? 8'(base + index) : base; // see (RULE19)
   end
endmodule
`default_nettype wire

// ### cao_operand_addr.sv
// Contract
// (RULE1) source immediate: operand one into selected register
// (RULE2) single operand modes are two bytes
// (RULE3) two operand modes are three bytes
// (RULE4) source direct reads ram or register space
// (RULE5) arithmetic source modes combine with register
// (RULE6) source indexed address is operand plus index
// (RULE7) destination direct writes memory, register unchanged
// (RULE8) arithmetic destination reads location first
// (RULE9) destination indexed: operand plus index, accumulator
// (RULE10) direct immediate: address, then immediate value
// (RULE11) indexed immediate: operand plus index, immediate
// (RULE12) direct direct copies ram, move only
// (RULE13) source indirect loads pointed byte into accumulator
// (RULE14) indirect modes increment stored pointer afterward
// (RULE15) destination indirect stores accumulator via pointer
// (RULE16) indirect modes only for indirect move
// (RULE17) bank bit selects register space bank
// (RULE18) fetch opcode then operands, pc advances
// (RULE19) indexed sum wraps, flags untouched
`timescale 1ns/1ps
`default_nettype none
`include "cao_regs.svh"
module cao_operand_addr (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic         run,
   output logic              pm_req,
   output logic      [15:0]  pm_addr,
   input  wire logic         pm_ack,
   input  wire logic [7:0]   pm_rdata,
   output cao_pkg::cao_dm_s  dm,
   input  wire logic         dm_ack,
   input  wire logic [7:0]   dm_rdata,
   output logic      [1:0]   alu_op,
   output logic      [7:0]   alu_a,
   output logic      [7:0]   alu_b,
   input  wire logic [7:0]   alu_y,
   input  wire logic         alu_carry,
   input  wire logic         alu_zero,
   output logic      [7:0]   reg_a,
   output logic      [7:0]   reg_x,
   output logic      [7:0]   reg_sp,
   output logic      [7:0]   reg_f,
   output logic      [15:0]  pc,
   output logic              instr_done,
   output logic              illegal_op
);
   // ==========================================================
   // state and helpers
   cao_pkg::cao_state_s s_ff;       // registered state
   cao_pkg::cao_state_s nxt_s;      // next state
   cao_pkg::cao_dec_s   dec;        // decoded opcode
   logic [7:0]          ea_w;       // formed address
   logic [7:0]          res;        // combined result

   // ==========================================================
   // decode of the held opcode
   cao_mode_dec u_dec (
      .opc (s_ff.opc),
      .dec (dec)
   );

   // ==========================================================
   // effective address from operand one and index
   cao_ea_add u_ea (
      .base    (s_ff.op1),
      .index   (s_ff.x),
      .indexed (dec.indexed),
      .ea      (ea_w)
   );

   // ==========================================================
   // move passes the source, otherwise the alu answer
   assign res = dec.is_move ? s_ff.alu_a : alu_y;

   // ==========================================================
   // read a core register by selection
   function automatic logic [7:0] reg_rd(
      input cao_pkg::cao_state_s s,
      input cao_pkg::cao_reg_e   r
   );
      case (r)
         cao_pkg::R_A:  reg_rd = s.a;
         cao_pkg::R_X:  reg_rd = s.x;
         cao_pkg::R_F:  reg_rd = s.f;
         cao_pkg::R_SP: reg_rd = s.sp;
         default:       reg_rd = s.a;
      endcase
   endfunction

   // ==========================================================
   // build a memory request; bank comes from the flag register
   function automatic cao_pkg::cao_dm_s mem_acc(
      input logic       we,
      input logic       regsp,
      input logic [7:0] addr,
      input logic [7:0] wdata,
      input logic [7:0] f
   );
      mem_acc.req   = 1'b1;
      mem_acc.we    = we;
      mem_acc.regsp = regsp;
      mem_acc.bank  = f[`CAO_F_BANK]; // see (RULE17)
      mem_acc.addr  = addr;
      mem_acc.wdata = wdata;
   endfunction

   // ==========================================================
   // sequencer next state
   always_comb begin
      nxt_s      = s_ff;
      nxt_s.done = 1'b0;
      nxt_s.bad  = 1'b0;
      case (s_ff.st)
         cao_pkg::ST_OPC: begin
            // opcode byte comes first
            if (s_ff.pm_req && pm_ack) begin
               nxt_s.pm_req = 1'b0;
               nxt_s.opc    = pm_rdata;
               nxt_s.pc     = s_ff.pc + `CAO_PC_STEP; // see (RULE18)
               nxt_s.st     = cao_pkg::ST_OP1;
            end else if (run && !s_ff.pm_req) begin
               nxt_s.pm_req = 1'b1;
            end
         end
         cao_pkg::ST_OP1: begin
            // first operand byte
            if (s_ff.pm_req && pm_ack) begin
               nxt_s.pm_req = 1'b0;
               nxt_s.op1    = pm_rdata;
               nxt_s.pc     = s_ff.pc + `CAO_PC_STEP; // see (RULE18)
               if (dec.len == `CAO_LEN_LONG) begin
                  nxt_s.st = cao_pkg::ST_OP2; // see (RULE3)
               end else begin
                  nxt_s.st = cao_pkg::ST_EXEC; // see (RULE2)
               end
            end else if (!s_ff.pm_req) begin
               nxt_s.pm_req = 1'b1;
            end
         end
         cao_pkg::ST_OP2: begin
            // second operand byte
            if (s_ff.pm_req && pm_ack) begin
               nxt_s.pm_req = 1'b0;
               nxt_s.op2    = pm_rdata;
               nxt_s.pc     = s_ff.pc + `CAO_PC_STEP; // see (RULE18)
               nxt_s.st     = cao_pkg::ST_EXEC;
            end else if (!s_ff.pm_req) begin
               nxt_s.pm_req = 1'b1;
            end
         end
         cao_pkg::ST_EXEC: begin
            nxt_s.ea = ea_w;
            if (!dec.legal) begin
               // unsupported mode or combination is dropped
               nxt_s.bad = 1'b1;
               nxt_s.st  = cao_pkg::ST_OPC;
            end else begin
               case (dec.mode)
                  cao_pkg::M_SIMM: begin
                     // immediate source, register second operand
                     nxt_s.alu_a = s_ff.op1; // see (RULE1)
                     nxt_s.alu_b = reg_rd(s_ff, dec.rsel);
                     nxt_s.st    = cao_pkg::ST_ALU;
                  end
                  cao_pkg::M_SDIR, cao_pkg::M_SIDX: begin
                     // read the source location
                     nxt_s.dm = mem_acc(1'b0, dec.space, ea_w, 8'h00, s_ff.f); // see (RULE4) (RULE6)
                     nxt_s.st = cao_pkg::ST_RSRC;
                  end
                  cao_pkg::M_DDIR, cao_pkg::M_DIDX,
                  cao_pkg::M_DDIMM, cao_pkg::M_DXIMM: begin
                     // source is a register or operand two
                     if (dec.mode == cao_pkg::M_DDIMM || dec.mode == cao_pkg::M_DXIMM) begin
                        nxt_s.srcv = s_ff.op2; // see (RULE10) (RULE11)
                     end else begin
                        nxt_s.srcv = reg_rd(s_ff, dec.rsel); // see (RULE7) (RULE9)
                     end
                     if (dec.is_move) begin
                        nxt_s.alu_a = nxt_s.srcv;
                        nxt_s.st    = cao_pkg::ST_ALU;
                     end else begin
                        // fetch old destination as second operand
                        nxt_s.dm = mem_acc(1'b0, dec.space, ea_w, 8'h00, s_ff.f); // see (RULE8)
                        nxt_s.st = cao_pkg::ST_RDST;
                     end
                  end
                  cao_pkg::M_DDD: begin
                     // ram source at operand two
                     nxt_s.dm = mem_acc(1'b0, 1'b0, s_ff.op2, 8'h00, s_ff.f); // see (RULE12)
                     nxt_s.st = cao_pkg::ST_RSRC;
                  end
                  cao_pkg::M_SIPI, cao_pkg::M_DIPI: begin
                     // read the stored pointer
                     nxt_s.dm = mem_acc(1'b0, 1'b0, s_ff.op1, 8'h00, s_ff.f); // see (RULE13) (RULE15)
                     nxt_s.st = cao_pkg::ST_RPTR;
                  end
                  default: begin
                     nxt_s.bad = 1'b1;
                     nxt_s.st  = cao_pkg::ST_OPC;
                  end
               endcase
            end
         end
         cao_pkg::ST_RSRC: begin
            // source byte arrives; register is second operand
            if (dm_ack) begin
               nxt_s.dm.req = 1'b0;
               nxt_s.alu_a  = dm_rdata;
               nxt_s.alu_b  = reg_rd(s_ff, dec.rsel); // see (RULE5)
               nxt_s.st     = cao_pkg::ST_ALU;
            end
         end
         cao_pkg::ST_RDST: begin
            // old destination value arrives
            if (dm_ack) begin
               nxt_s.dm.req = 1'b0;
               nxt_s.alu_a  = s_ff.srcv;
               nxt_s.alu_b  = dm_rdata; // see (RULE8)
               nxt_s.st     = cao_pkg::ST_ALU;
            end
         end
         cao_pkg::ST_ALU: begin
            // flags follow arithmetic only
            if (!dec.is_move) begin
               nxt_s.f[`CAO_F_CARRY] = alu_carry;
               nxt_s.f[`CAO_F_ZERO]  = alu_zero;
            end
            if (dec.dest_mem) begin
               // memory destination, source register kept
               nxt_s.dm = mem_acc(1'b1, dec.space, s_ff.ea, res, s_ff.f); // see (RULE7)
               nxt_s.st = cao_pkg::ST_WAITW;
            end else begin
               case (dec.rsel)
                  cao_pkg::R_A: nxt_s.a = res; // see (RULE5)
                  cao_pkg::R_X: nxt_s.x = res;
                  cao_pkg::R_F: begin
                     // supervisory bit is read-only
                     nxt_s.f = res;
                     nxt_s.f[`CAO_F_SUPER] = s_ff.f[`CAO_F_SUPER];
                  end
                  cao_pkg::R_SP: nxt_s.sp = res;
                  default: nxt_s.a = res;
               endcase
               nxt_s.done = 1'b1;
               nxt_s.st   = cao_pkg::ST_OPC;
            end
         end
         cao_pkg::ST_RPTR: begin
            // pointer arrives; use it for the data access
            if (dm_ack) begin
               nxt_s.ptr = dm_rdata;
               if (dec.mode == cao_pkg::M_SIPI) begin
                  nxt_s.dm = mem_acc(1'b0, 1'b0, dm_rdata, 8'h00, s_ff.f); // see (RULE13)
               end else begin
                  nxt_s.dm = mem_acc(1'b1, 1'b0, dm_rdata, s_ff.a, s_ff.f); // see (RULE15)
               end
               nxt_s.st = cao_pkg::ST_RIND;
            end
         end
         cao_pkg::ST_RIND: begin
            // data moved; now write pointer plus one back
            if (dm_ack) begin
               if (dec.mode == cao_pkg::M_SIPI) begin
                  nxt_s.a = dm_rdata; // see (RULE13)
               end
               nxt_s.dm = mem_acc(1'b1, 1'b0, s_ff.op1,
                                  8'(s_ff.ptr + `CAO_PTR_STEP), s_ff.f); // see (RULE14)
               nxt_s.st = cao_pkg::ST_WAITW;
            end
         end
         cao_pkg::ST_WAITW: begin
            // last write accepted ends the instruction
            if (dm_ack) begin
               nxt_s.dm.req = 1'b0;
               nxt_s.done   = 1'b1;
               nxt_s.st     = cao_pkg::ST_OPC;
            end
         end
         default: begin
            nxt_s.st = cao_pkg::ST_OPC;
         end
      endcase
   end

   // ==========================================================
   // state register with power-on values
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_ff    <= '0;
         s_ff.st <= cao_pkg::ST_OPC;
         s_ff.pc <= `CAO_PC_POR;
         s_ff.a  <= `CAO_A_POR;
         s_ff.x  <= `CAO_X_POR;
         s_ff.sp <= `CAO_SP_POR;
         s_ff.f  <= `CAO_F_POR;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ==========================================================
   // outputs straight from the state register, alu_op through the decoder
   assign pm_req     = s_ff.pm_req;
   assign pm_addr    = s_ff.pc;
   assign dm         = s_ff.dm;
   assign alu_op     = dec.alu_op;
   assign alu_a      = s_ff.alu_a;
   assign alu_b      = s_ff.alu_b;
   assign reg_a      = s_ff.a;
   assign reg_x      = s_ff.x;
   assign reg_sp     = s_ff.sp;
   assign reg_f      = s_ff.f;
   assign pc         = s_ff.pc;
   assign instr_done = s_ff.done;
   assign illegal_op = s_ff.bad;
endmodule
`default_nettype wire

// ### cao_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cao_mem_model (
   input  wire logic             sys_clk,
   input  wire logic             pm_req,
   input  wire logic [15:0]      pm_addr,
   output logic                  pm_ack,
   output logic      [7:0]       pm_rdata,
   input  wire cao_pkg::cao_dm_s dm,
   output logic                  dm_ack,
   output logic      [7:0]       dm_rdata,
   input  wire logic [1:0]       alu_op,
   input  wire logic [7:0]       alu_a,
   input  wire logic [7:0]       alu_b,
   output logic      [7:0]       alu_y,
   output logic                  alu_carry,
   output logic                  alu_zero
);
   // ==========================================
   // storage: program, ram, two register banks
   logic [7:0] pmem [256];
   logic [7:0] ram  [256];
   logic [7:0] regs [512];
   logic [8:0] sum;
   // answers come after a random wait; idle data toggles
   always @(negedge sys_clk) begin
      if (pm_req && !pm_ack && $urandom % 3 != 0) begin
         pm_ack <= 1'b1;
         pm_rdata <= pmem[pm_addr[7:0]];
      end else begin
         pm_ack <= 1'b0;
         pm_rdata <= ~pm_rdata;
      end
      if (dm.req && !dm_ack && $urandom % 3 != 0) begin
         dm_ack <= 1'b1;
         dm_rdata <= dm.regsp ? regs[{dm.bank, dm.addr}] : ram[dm.addr];
      end else begin
         dm_ack <= 1'b0;
         dm_rdata <= ~dm_rdata;
      end
   end
   // writes land on the accepting edge
   always @(posedge sys_clk) begin
      if (dm.req && dm_ack && dm.we && dm.regsp) regs[{dm.bank, dm.addr}] <= dm.wdata;
      if (dm.req && dm_ack && dm.we && !dm.regsp) ram[dm.addr] <= dm.wdata;
   end
   // alu: 1 add, 2 and, 3 xor
   always_comb begin
      sum = {1'b0, alu_a} + {1'b0, alu_b};
      alu_y = alu_op == 2'h1 ? sum[7:0] : (alu_op == 2'h2 ? alu_a & alu_b : alu_a ^ alu_b);
      alu_carry = alu_op == 2'h1 && sum[8];
      alu_zero = alu_y == 8'h00;
   end
endmodule
`default_nettype wire

// ### cao_operand_addr_props.sv
`timescale 1ns/1ps
`default_nettype none
module cao_operand_addr_props (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             pm_req,
   input  wire logic [15:0]      pm_addr,
   input  wire logic             pm_ack,
   input  wire cao_pkg::cao_dm_s dm,
   input  wire logic             dm_ack,
   input  wire logic [7:0]       reg_a,
   input  wire logic [7:0]       reg_x,
   input  wire logic [7:0]       reg_f,
   input  wire logic [15:0]      pc,
   input  wire logic             instr_done,
   input  wire logic             illegal_op
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // ==========================================
   // fetch steps
   sequence fetch_take;
      pm_req && pm_ack;
   endsequence
   sequence fetch_gap;
      !pm_req;
   endsequence
   port_excl_a: assert property (!(pm_req && dm.req))
      else $error("fetch during data access");
   fetch_hold_a: assert property (pm_req && !pm_ack |=> pm_req && $stable(pm_addr))
      else $error("fetch request not held");
   fetch_step_a: assert property (fetch_take |=> fetch_gap ##0 pc == $past(pc) + 16'h0001)
      else $error("pc did not step after fetch");
   pc_moves_a: assert property (!$stable(pc) |-> $past(pm_req) && $past(pm_ack))
      else $error("pc moved without fetch");
   // ==========================================
   // data port
   dm_hold_a: assert property (dm.req && !dm_ack |=> $stable(dm))
      else $error("data request changed before ack");
   bank_sel_a: assert property (dm.req && dm.regsp |-> dm.bank == reg_f[4])
      else $error("bank differs from flag");
   src_keep_a: assert property (dm.req && dm.we && !dm_ack |=> $stable(reg_a) && $stable(reg_x))
      else $error("register changed during write");
   super_keep_a: assert property ($stable(reg_f[3]))
      else $error("supervisor bit changed");
   done_pulse_a: assert property (instr_done |=> !instr_done)
      else $error("done longer than a cycle");
   done_excl_a: assert property (!(instr_done && illegal_op))
      else $error("done and illegal together");
endmodule
bind cao_operand_addr cao_operand_addr_props chk (.sys_clk, .sys_rst, .pm_req, .pm_addr,
   .pm_ack, .dm, .dm_ack, .reg_a, .reg_x, .reg_f, .pc, .instr_done, .illegal_op);
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   // ==========================================
   // design signals
   logic             sys_clk, sys_rst, run, pm_req, pm_ack, dm_ack;
   logic             alu_carry, alu_zero, instr_done, illegal_op;
   logic [15:0]      pm_addr, pc;
   logic [7:0]       pm_rdata, dm_rdata, alu_a, alu_b, alu_y;
   logic [7:0]       reg_a, reg_x, reg_sp, reg_f;
   logic [1:0]       alu_op;
   cao_pkg::cao_dm_s dm;
   // model state, last write, counters
   int               miscompares, num_checks;
   int               a, x, sp, f, pcm, e_ill, ls, li, lv;
   int               rm [256];
   int               rg [512];
   int               pmb [256];
   cao_operand_addr dut (.sys_clk, .sys_rst, .run, .pm_req, .pm_addr, .pm_ack, .pm_rdata,
      .dm, .dm_ack, .dm_rdata, .alu_op, .alu_a, .alu_b, .alu_y, .alu_carry, .alu_zero,
      .reg_a, .reg_x, .reg_sp, .reg_f, .pc, .instr_done, .illegal_op);
   cao_mem_model mdl (.sys_clk, .pm_req, .pm_addr, .pm_ack, .pm_rdata, .dm, .dm_ack,
      .dm_rdata, .alu_op, .alu_a, .alu_b, .alu_y, .alu_carry, .alu_zero);
   // ==========================================
   // compare and finish
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (miscompares == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================
   // reference model
   function automatic int alu(int p, int q, int op);
      int y;
      y = op == 1 ? p + q : (op == 2 ? p & q : p ^ q);
      f = (f & 'hF9) | ((y > 255) << 2) | (((y & 255) == 0) << 1);
      return y & 255;
   endfunction
   function automatic int rd(int s, int ad);
      return s ? rg[(f & 16) * 16 + ad] : rm[ad];
   endfunction
   task automatic wr(int s, int ad, int v);
      ls = s;
      li = s ? (f & 16) * 16 + ad : ad;
      lv = v;
      if (s) rg[li] = v;
      else rm[li] = v;
   endtask
   // source modes into a core register
   task automatic put(int r, int op, int v);
      int y;
      y = op ? alu(v, r == 0 ? a : x, op) : v;
      case (r)
         0: a = y;
         1: x = y;
         2: f = (y & 'hF7) | (f & 8);
         default: sp = y;
      endcase
   endtask
   task automatic step();
      int o, m, op, b1, b2, ad, s, v, p;
      o = pmb[pcm];
      b1 = pmb[pcm + 1];
      b2 = pmb[pcm + 2];
      m = o >> 4;
      op = o & 3;
      s = (o >> 3) & 1;
      e_ill = m > 9 || (m > 6 && op != 0);
      pcm += (m > 4 && m < 8) ? 3 : 2;
      ad = (m == 2 || m == 4 || m == 6) ? (b1 + x) & 255 : b1;
      ls = -1;
      if (!e_ill) case (m)
         0: put((o >> 2) & 3, op, b1);
         1, 2: put((o >> 2) & 1, op, rd(s, ad));
         7: wr(0, b1, rm[b2]);
         8, 9: begin
            p = rm[b1];
            if (m == 8) a = rm[p];
            else wr(0, p, a);
            wr(0, b1, (p + 1) & 255);
         end
         default: begin
            v = m == 3 ? (((o >> 2) & 1) ? x : a) : (m == 4 ? a : b2);
            wr(s, ad, op ? alu(v, rd(s, ad), op) : v);
         end
      endcase
   endtask
   // ==========================================
   // clock, watchdog, main sequence
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      #100000;
      miscompares++;
      stop_test();
   end
   initial begin
      int k, n, p, m, op, r, sd;
      sd = $urandom(5);
      sys_rst = 1'b1;
      run = 1'b0;
      a = 0; x = 0; sp = 0; f = 2; pcm = 0; k = 0; p = 0;
      for (int i = 0; i < 512; i++) begin
         rg[i] = $urandom % 256;
         mdl.regs[i] = 8'(rg[i]);
      end
      for (int i = 0; i < 256; i++) begin
         rm[i] = $urandom % 256;
         pmb[i] = $urandom % 256;
      end
      // random opcodes at instruction starts, illegal ones included
      while (p < 240) begin
         m = $urandom % 11;
         if (m == 10) m += $urandom % 6;
         op = ($urandom % 2) ? $urandom % 4 : 0;
         r = $urandom % 4;
         if (m == 0 && r > 1) op = 0;
         pmb[p] = m * 16 + r * 4 + op;
         p += (m > 4 && m < 8) ? 3 : 2;
         k++;
      end
      for (int i = 0; i < 256; i++) begin
         mdl.pmem[i] = 8'(pmb[i]);
         mdl.ram[i] = 8'(rm[i]);
      end
      repeat (3) @(negedge sys_clk);
      chk(16'(reg_f), 16'h0002);
      chk(pc, 16'h0000);
      sys_rst = 1'b0;
      run = 1'b1;
      repeat (k) begin
         n = 0;
         do begin
            @(negedge sys_clk);
            n++;
         end while (instr_done !== 1'b1 && illegal_op !== 1'b1 && n < 300);
         if (n >= 300) miscompares++;
         step();
         chk(16'(illegal_op), 16'(e_ill));
         chk(pc, 16'(pcm));
         chk(16'(reg_a), 16'(a));
         chk(16'(reg_x), 16'(x));
         chk(16'(reg_sp), 16'(sp));
         chk(16'(reg_f), 16'(f));
         if (ls >= 0) chk(16'(ls ? mdl.regs[li] : mdl.ram[li]), 16'(lv));
      end
      for (int i = 0; i < 256; i++) chk(16'(mdl.ram[i]), 16'(rm[i]));
      stop_test();
   end
endmodule
`default_nettype wire
